// File: core/plfl_pkg.sv
`default_nettype none
package plfl_pkg;

    // Holding register indices
    localparam logic [7:0] ADDR_STACK_LIM = 8'h00;
    localparam logic [7:0] ADDR_AMB_HI = 8'h01;
    localparam logic [7:0] ADDR_AMB_LO = 8'h02;
    localparam logic [7:0] ADDR_FAULT_BASE = 8'h10;

    // Scale factors from degrees C to register counts
    localparam int STACK_SCALE = 4;
    localparam int AMB_SCALE = 16;

    // Limits in degrees C
    localparam int STACK_DEF_C = 482;
    localparam int STACK_MIN_C = 38;
    localparam int STACK_MAX_C = 1024;
    localparam int AMB_HI_DEF_C = 85;
    localparam int AMB_HI_MIN_C = 65;
    localparam int AMB_HI_MAX_C = 125;
    localparam int AMB_LO_DEF_C = -25;
    localparam int AMB_LO_MIN_C = -55;
    localparam int AMB_LO_MAX_C = -15;

    // Limits as register values
    localparam logic [15:0] STACK_DEF = 16'(STACK_DEF_C * STACK_SCALE);
    localparam logic [15:0] STACK_MIN = 16'(STACK_MIN_C * STACK_SCALE);
    localparam logic [15:0] STACK_MAX = 16'(STACK_MAX_C * STACK_SCALE);
    localparam logic [15:0] AMB_HI_DEF = 16'(AMB_HI_DEF_C * AMB_SCALE);
    localparam logic [15:0] AMB_HI_MIN = 16'(AMB_HI_MIN_C * AMB_SCALE);
    localparam logic [15:0] AMB_HI_MAX = 16'(AMB_HI_MAX_C * AMB_SCALE);
    localparam logic signed [15:0] AMB_LO_DEF = 16'(AMB_LO_DEF_C * AMB_SCALE);
    localparam logic signed [15:0] AMB_LO_MIN = 16'(AMB_LO_MIN_C * AMB_SCALE);
    localparam logic signed [15:0] AMB_LO_MAX = 16'(AMB_LO_MAX_C * AMB_SCALE);

    // Ambient field codes of the status word
    localparam logic [1:0] AMB_OK = 2'h0;
    localparam logic [1:0] AMB_UNREAD = 2'h1;
    localparam logic [1:0] AMB_OVER = 2'h2;
    localparam logic [1:0] AMB_UNDER = 2'h3;

    // Fault module codes
    localparam logic [3:0] FMOD_CPU = 4'h1;
    localparam logic [3:0] FMOD_STACK = 4'h2;
    localparam logic [3:0] FMOD_AMB = 4'h3;
    localparam logic [3:0] FMOD_O2 = 4'h4;

    // Temperature module fault types
    localparam logic [3:0] FT_TEMP_DISC = 4'h0;
    localparam logic [3:0] FT_TEMP_OVER = 4'h1;
    localparam logic [3:0] FT_TEMP_LOW = 4'h2;
    localparam logic [3:0] FT_TEMP_COMMS = 4'h3;

    // Processor fault types
    localparam logic [3:0] FT_CPU_CRC = 4'h0;
    localparam logic [3:0] FT_CPU_OVERWRITE = 4'h1;
    localparam logic [3:0] FT_CPU_MEM = 4'h2;
    localparam logic [3:0] FT_CPU_INSTR = 4'h3;
    localparam logic [3:0] FT_CPU_STATE = 4'h4;
    localparam logic [3:0] FT_CPU_RESET = 4'h5;

    // One-hot reset cause subtypes
    localparam logic [7:0] RST_HARDWARE = 8'h01;
    localparam logic [7:0] RST_SUPPLY = 8'h02;
    localparam logic [7:0] RST_MISSED_CLK = 8'h04;
    localparam logic [7:0] RST_WATCHDOG = 8'h08;
    localparam logic [7:0] software_reset_cause = 8'h10;
    localparam logic [7:0] comparator_reset_cause = 8'h20;
    localparam logic [7:0] RST_FLASH_ERR = 8'h40;

    // Oxygen sensor device fault subtypes
    localparam logic [3:0] FT_O2_DEVICE = 4'h0;
    localparam logic [7:0] O2_HEATER_SHORT = 8'h01;
    localparam logic [7:0] O2_HEATER_OPEN = 8'h02;
    localparam logic [7:0] O2_PUMP_SHORT = 8'h03;
    localparam logic [7:0] O2_PUMP_OPEN = 8'h04;
    localparam logic [7:0] O2_REF_SHORT = 8'h05;
    localparam logic [7:0] O2_REF_OPEN = 8'h06;
    localparam logic [7:0] O2_TIMEOUT = 8'h08;

    // One fault record: identity word then data word
    typedef struct packed {
        logic [3:0] fmod;
        logic [3:0] ftype;
        logic [7:0] fsub;
        logic [15:0] fdata;
    } plfl_fault_t;

endpackage : plfl_pkg
`default_nettype wire

// File: core/plfl_bank.sv
// Overview of operation
// - Stack upper limit register holds degrees C times four.
// - Stack limit defaults to 482 C, range 38..1024 C, drives stack flag.
// - Ambient upper limit sets the over-temperature threshold of ambient field.
// - Ambient upper limit resets to 85 C.
// - Ambient upper limit accepts only 65..125 C.
// - Ambient upper limit register holds degrees C times sixteen.
// - Ambient lower limit sets the under-temperature threshold of ambient field.
// - Ambient lower limit resets to minus 25 C.
// - Ambient lower limit accepts only minus 55..minus 15 C.
// - Ambient lower limit holds signed degrees C times sixteen.
// - One holding-register write changes a limit, effective as active threshold.
// - Ambient field: 0 normal, 1 unreadable, 2 over, 3 under.
// - Keep the ten most recent fault records.
// - Each record is two 16-bit registers, written on detection.
// - Identity word: module 15..12, type 11..8, subtype 7..0.
// - Data word holds the 16-bit value tested at detection.
// - Module codes 1 cpu, 2 stack, 3 ambient, 4 oxygen; temp types.
// - Processor fault types 0 checksum through 5 reset.
// - Reset subtype is a one-hot cause code.
// - Oxygen device fault subtypes 1..6 and 8.
`default_nettype none
module plfl_bank #(
    parameter int DEPTH = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Holding register access
    input wire logic hr_wr_i,
    input wire logic hr_rd_i,
    input wire logic [7:0] hr_addr_i,
    input wire logic [15:0] hr_wdata_i,
    output logic [15:0] hr_rdata_o,
    output logic hr_rvalid_o,
    output logic hr_wack_o,
    output logic hr_exc_o,
    // Measurements from the conversion logic
    input wire logic [15:0] stack_temp_i,
    input wire logic [15:0] amb_temp_i,
    input wire logic amb_unread_i,
    // Fault detection
    input wire logic fault_valid_i,
    input wire plfl_pkg::plfl_fault_t fault_i,
    // Status fields and history state
    output logic stack_over_o,
    output logic [1:0] amb_status_o,
    output logic [3:0] fault_count_o
);

    localparam int IDXW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [8:0] DEPTH9 = 9'(DEPTH);
    localparam logic [8:0] DEPTH_M1 = 9'(DEPTH - 1);
    localparam logic [IDXW-1:0] LAST_SLOT = IDXW'(DEPTH - 1);
    localparam logic [3:0] COUNT_FULL = 4'(DEPTH);

    // Refuse depths the pointer, count and address map cannot serve
    if (DEPTH < 1 || DEPTH > 15)
    begin : g_bad_depth
        $error("plfl_bank: DEPTH must lie in 1..15");
    end

    logic [15:0] stack_lim_q;
    logic [15:0] amb_hi_q;
    logic signed [15:0] amb_lo_q;
    plfl_pkg::plfl_fault_t mem_q [DEPTH];
    logic [IDXW-1:0] wp_q;
    logic [3:0] count_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic wack_q;
    logic exc_q;
    logic stack_over_q;
    logic [1:0] amb_status_q;

    // Address decode
    wire logic sel_stack = (hr_addr_i == plfl_pkg::ADDR_STACK_LIM);
    wire logic sel_hi = (hr_addr_i == plfl_pkg::ADDR_AMB_HI);
    wire logic sel_lo = (hr_addr_i == plfl_pkg::ADDR_AMB_LO);
    wire logic [7:0] fault_off = hr_addr_i - plfl_pkg::ADDR_FAULT_BASE;
    wire logic [7:0] rec_idx = {1'b0, fault_off[7:1]};
    wire logic sel_fault = (hr_addr_i >= plfl_pkg::ADDR_FAULT_BASE)
                         && (rec_idx < 8'(DEPTH));

    // Range checks of written values
    wire logic [15:0] wd = hr_wdata_i;
    wire logic signed [15:0] wd_s = $signed(hr_wdata_i);
    wire logic stack_in_range = (wd >= plfl_pkg::STACK_MIN)
                              && (wd <= plfl_pkg::STACK_MAX);
    wire logic hi_in_range = (wd >= plfl_pkg::AMB_HI_MIN)
                           && (wd <= plfl_pkg::AMB_HI_MAX);
    wire logic lo_in_range = (wd_s >= plfl_pkg::AMB_LO_MIN)
                           && (wd_s <= plfl_pkg::AMB_LO_MAX);
    wire logic wr_stack = hr_wr_i && sel_stack && stack_in_range;
    wire logic wr_hi = hr_wr_i && sel_hi && hi_in_range;
    wire logic wr_lo = hr_wr_i && sel_lo && lo_in_range;
    wire logic wr_ok = wr_stack || wr_hi || wr_lo;

    // Record index 0 is the newest; slot counts back from the write pointer
    wire logic [8:0] back_sum = 9'(wp_q) + DEPTH_M1 - 9'(rec_idx);
    wire logic [8:0] back_slot = (back_sum >= DEPTH9)
                               ? back_sum - DEPTH9 : back_sum;
    wire logic [IDXW-1:0] slot = back_slot[IDXW-1:0];
    wire plfl_pkg::plfl_fault_t rec = mem_q[slot];
    wire logic [15:0] rec_id = {rec.fmod, rec.ftype, rec.fsub};
    wire logic [15:0] rec_word = fault_off[0] ? rec.fdata : rec_id;

    // Read data selection; unmapped reads give zero
    wire logic [15:0] rd_mux = sel_stack ? stack_lim_q
                             : sel_hi ? amb_hi_q
                             : sel_lo ? amb_lo_q
                             : sel_fault ? rec_word
                             : 16'h0000;
    wire logic rd_bad = !(sel_stack || sel_hi || sel_lo || sel_fault);

    // Status field evaluation against the active limits
    wire logic stack_over_d = (stack_temp_i > stack_lim_q);
    wire logic signed [15:0] amb_s = $signed(amb_temp_i);
    wire logic [1:0] amb_status_d = amb_unread_i ? plfl_pkg::AMB_UNREAD
                                  : (amb_s > $signed(amb_hi_q))
                                  ? plfl_pkg::AMB_OVER
                                  : (amb_s < amb_lo_q)
                                  ? plfl_pkg::AMB_UNDER
                                  : plfl_pkg::AMB_OK;

    // Ring pointer and fill count of the history
    wire logic [IDXW-1:0] wp_d = (wp_q == LAST_SLOT)
                               ? '0 : wp_q + 1'b1;
    wire logic [3:0] count_d = (count_q == COUNT_FULL)
                             ? count_q : count_q + 4'h1;

    // Limit registers with their reset defaults
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stack_lim_q <= plfl_pkg::STACK_DEF;
            amb_hi_q <= plfl_pkg::AMB_HI_DEF;
            amb_lo_q <= plfl_pkg::AMB_LO_DEF;
        end
        else
        begin
            if (wr_stack)
                stack_lim_q <= hr_wdata_i;
            if (wr_hi)
                amb_hi_q <= hr_wdata_i;
            if (wr_lo)
                amb_lo_q <= wd_s;
        end
    end

    // Fault history ring
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
            wp_q <= '0;
            count_q <= 4'h0;
        end
        else if (fault_valid_i)
        begin
            mem_q[wp_q] <= fault_i;
            wp_q <= wp_d;
            count_q <= count_d;
        end
    end

    // Bus answers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            wack_q <= 1'b0;
            exc_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= hr_rd_i && !hr_wr_i;
            wack_q <= hr_wr_i && wr_ok;
            exc_q <= (hr_wr_i && !wr_ok) || (hr_rd_i && !hr_wr_i && rd_bad);
            if (hr_rd_i && !hr_wr_i)
                rdata_q <= rd_mux;
        end
    end

    // Status fields
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stack_over_q <= 1'b0;
            amb_status_q <= plfl_pkg::AMB_OK;
        end
        else
        begin
            stack_over_q <= stack_over_d;
            amb_status_q <= amb_status_d;
        end
    end

    assign hr_rdata_o = rdata_q;
    assign hr_rvalid_o = rvalid_q;
    assign hr_wack_o = wack_q;
    assign hr_exc_o = exc_q;
    assign stack_over_o = stack_over_q;
    assign amb_status_o = amb_status_q;
    assign fault_count_o = count_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_lim_wr;
        hr_wr_i && sel_hi && hi_in_range;
    endsequence

    sequence s_bad_wr;
        hr_wr_i && sel_stack && !stack_in_range;
    endsequence

    sequence s_stack_wr;
        hr_wr_i && sel_stack && stack_in_range;
    endsequence

    sequence s_lo_wr;
        hr_wr_i && sel_lo && lo_in_range;
    endsequence

    // A stored fault followed at once by a read of the newest identity word
    sequence s_store_read;
        fault_valid_i ##1 (hr_rd_i && !hr_wr_i && !fault_valid_i
        && hr_addr_i == plfl_pkg::ADDR_FAULT_BASE);
    endsequence

    a_hi_write_takes: assert property (
        s_lim_wr |=> amb_hi_q == $past(hr_wdata_i) && hr_wack_o)
        else $error("ambient high limit not updated");

    a_bad_write_kept: assert property (
        s_bad_wr |=> $stable(stack_lim_q) && hr_exc_o && !hr_wack_o)
        else $error("out-of-range stack write changed limit");

    a_lo_in_range: assert property (
        amb_lo_q >= plfl_pkg::AMB_LO_MIN && amb_lo_q <= plfl_pkg::AMB_LO_MAX)
        else $error("ambient low limit out of range");

    a_amb_over_flag: assert property (
        !amb_unread_i && amb_s > $signed(amb_hi_q)
        |=> amb_status_o == plfl_pkg::AMB_OVER)
        else $error("ambient over not flagged");

    a_amb_under_flag: assert property (
        !amb_unread_i && amb_s < amb_lo_q && amb_s <= $signed(amb_hi_q)
        |=> amb_status_o == plfl_pkg::AMB_UNDER)
        else $error("ambient under not flagged");

    a_stack_over_flag: assert property (
        stack_over_d |=> stack_over_o)
        else $error("stack over not flagged");

    a_fault_stored: assert property (
        fault_valid_i |=> mem_q[$past(wp_q)] == $past(fault_i))
        else $error("fault record not written");

    a_ring_wraps: assert property (
        fault_valid_i && wp_q == LAST_SLOT |=> wp_q == '0)
        else $error("history pointer did not wrap");

    a_count_bound: assert property (
        count_q <= COUNT_FULL)
        else $error("fault count beyond depth");

    a_newest_read: assert property (
        s_store_read
        |=> hr_rdata_o == {$past(fault_i.fmod, 2), $past(fault_i.ftype, 2),
                           $past(fault_i.fsub, 2)})
        else $error("newest record identity word wrong");

    // Further limit, status and history checks
    a_stack_write_takes: assert property (
        s_stack_wr |=> stack_lim_q == $past(hr_wdata_i) && hr_wack_o)
        else $error("stack limit not updated");

    a_lo_write_takes: assert property (
        s_lo_wr |=> amb_lo_q == $past(wd_s) && hr_wack_o)
        else $error("ambient low limit not updated");

    a_hi_bad_kept: assert property (
        hr_wr_i && sel_hi && !hi_in_range
        |=> $stable(amb_hi_q) && hr_exc_o && !hr_wack_o)
        else $error("out-of-range ambient high write changed limit");

    a_lo_bad_kept: assert property (
        hr_wr_i && sel_lo && !lo_in_range
        |=> $stable(amb_lo_q) && hr_exc_o && !hr_wack_o)
        else $error("out-of-range ambient low write changed limit");

    a_hi_in_range: assert property (
        amb_hi_q >= plfl_pkg::AMB_HI_MIN && amb_hi_q <= plfl_pkg::AMB_HI_MAX)
        else $error("ambient high limit out of range");

    a_unread_flag: assert property (
        amb_unread_i |=> amb_status_o == plfl_pkg::AMB_UNREAD)
        else $error("unreadable ambient not flagged");

    a_amb_ok_flag: assert property (
        !amb_unread_i && amb_s <= $signed(amb_hi_q) && amb_s >= amb_lo_q
        |=> amb_status_o == plfl_pkg::AMB_OK)
        else $error("ambient normal not reported");

    a_stack_clear: assert property (
        !stack_over_d |=> !stack_over_o)
        else $error("stack over flagged below limit");

    a_count_step: assert property (
        fault_valid_i && count_q != COUNT_FULL
        |=> count_q == $past(count_q) + 4'h1)
        else $error("fault count did not advance");

    a_count_hold: assert property (
        fault_valid_i && count_q == COUNT_FULL |=> count_q == COUNT_FULL)
        else $error("fault count left full");

endmodule : plfl_bank
`default_nettype wire

// File: bench/plfl_master.sv
`default_nettype none
module plfl_master (
    // Clock
    input wire logic clk_i,
    // Requests
    output logic hr_wr_o,
    output logic hr_rd_o,
    output logic [7:0] hr_addr_o,
    output logic [15:0] hr_wdata_o,
    // Answers
    input wire logic [15:0] hr_rdata_i,
    input wire logic hr_rvalid_i,
    input wire logic hr_wack_i,
    input wire logic hr_exc_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial
    begin
        hr_wr_o = 1'b0;
        hr_rd_o = 1'b0;
        hr_addr_o = 8'h00;
        hr_wdata_o = 16'h0000;
    end

    // One pulsed request; caller scales values, out-of-range values are sent as given
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [15:0] wd, output logic [15:0] rd,
        output logic exc, output logic ok);
        int i;
        @(posedge clk_i);
        #1;
        hr_wr_o = wr;
        hr_rd_o = !wr;
        hr_addr_o = a;
        hr_wdata_o = wd;
        @(posedge clk_i);
        #1;
        // Released lines do not keep their old value
        hr_wr_o = 1'b0;
        hr_rd_o = 1'b0;
        hr_addr_o = ~a;
        hr_wdata_o = ~wd;
        ok = 1'b0;
        exc = 1'b0;
        rd = 16'h0000;
        for (i = 0; i < 4 && !ok; i++)
        begin
            if ((hr_wack_i | hr_rvalid_i | hr_exc_i) === 1'b1)
            begin
                ok = 1'b1;
                exc = hr_exc_i;
                rd = hr_rdata_i;
            end
            else
            begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask : xfer
endmodule : plfl_master
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, resetn_i, hr_wr, hr_rd, hr_rvalid, hr_wack, hr_exc;
    logic amb_unread, fault_valid, stack_over;
    logic [7:0] hr_addr;
    logic [15:0] hr_wdata, hr_rdata, stack_temp, amb_temp;
    logic [1:0] amb_status;
    logic [3:0] fault_count;
    plfl_pkg::plfl_fault_t fault;
    logic [15:0] ids [11] = '{16'h1000, 16'h1510, 16'h1520, 16'h1501,
        16'h1540, 16'h2100, 16'h3200, 16'h4001, 16'h4008, 16'h1403, 16'h1203};
    int n_fail = 0;
    int comparisons = 0;

    plfl_bank u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hr_wr_i(hr_wr),
        .hr_rd_i(hr_rd), .hr_addr_i(hr_addr), .hr_wdata_i(hr_wdata),
        .hr_rdata_o(hr_rdata), .hr_rvalid_o(hr_rvalid), .hr_wack_o(hr_wack),
        .hr_exc_o(hr_exc), .stack_temp_i(stack_temp), .amb_temp_i(amb_temp),
        .amb_unread_i(amb_unread), .fault_valid_i(fault_valid),
        .fault_i(fault), .stack_over_o(stack_over),
        .amb_status_o(amb_status), .fault_count_o(fault_count));
    plfl_master u_master (.clk_i(clk_i), .hr_wr_o(hr_wr), .hr_rd_o(hr_rd),
        .hr_addr_o(hr_addr), .hr_wdata_o(hr_wdata), .hr_rdata_i(hr_rdata),
        .hr_rvalid_i(hr_rvalid), .hr_wack_i(hr_wack), .hr_exc_i(hr_exc));

    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("Counts: n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Register access with its expected answer
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [15:0] wd, input logic [15:0] exp, input logic ex);
        logic [15:0] d;
        logic e, ok;
        u_master.xfer(wr, a, wd, d, e, ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("ERROR answer expected 1 seen 0");
            stop_test();
        end
        chk("exception", {15'h0000, ex}, {15'h0000, e});
        chk("write ack", {15'h0000, wr && !ex}, {15'h0000, hr_wack});
        chk("read valid", {15'h0000, !wr}, {15'h0000, hr_rvalid});
        if (!wr)
            chk("read data", exp, d);
    endtask : acc

    // Drive measurements, then look at the registered status
    task automatic stat(input logic [15:0] st, input logic [15:0] at,
        input logic un, input logic so, input logic [1:0] as);
        @(posedge clk_i);
        #1;
        stack_temp = st;
        amb_temp = at;
        amb_unread = un;
        repeat (2) @(posedge clk_i);
        #1;
        chk("stack_over", {15'h0000, so}, {15'h0000, stack_over});
        chk("amb_status", {14'h0000, as}, {14'h0000, amb_status});
    endtask : stat

    task automatic t_reset();
        acc(1'b0, 8'h00, 16'h0000, 16'h0788, 1'b0);
        acc(1'b0, 8'h01, 16'h0000, 16'h0550, 1'b0);
        acc(1'b0, 8'h02, 16'h0000, 16'hFE70, 1'b0);
        acc(1'b0, 8'h11, 16'h0000, 16'h0000, 1'b0);
        chk("fault_count", 16'h0000, {12'h000, fault_count});
    endtask : t_reset

    task automatic t_limits();
        acc(1'b1, 8'h01, 16'h0410, 16'h0000, 1'b0);
        acc(1'b1, 8'h01, 16'h07D1, 16'h0000, 1'b1);
        acc(1'b0, 8'h01, 16'h0000, 16'h0410, 1'b0);
        acc(1'b1, 8'h02, 16'hFC90, 16'h0000, 1'b0);
        acc(1'b1, 8'h02, 16'hFF11, 16'h0000, 1'b1);
        acc(1'b0, 8'h02, 16'h0000, 16'hFC90, 1'b0);
        acc(1'b1, 8'h00, 16'h1001, 16'h0000, 1'b1);
        acc(1'b1, 8'h00, 16'h0098, 16'h0000, 1'b0);
        acc(1'b0, 8'h00, 16'h0000, 16'h0098, 1'b0);
        acc(1'b0, 8'h03, 16'h0000, 16'h0000, 1'b1);
    endtask : t_limits

    // Limits now: stack 152, ambient high 1040, ambient low -880
    task automatic t_status();
        stat(16'h0099, 16'h0411, 1'b0, 1'b1, 2'h2);
        stat(16'h0098, 16'h0410, 1'b0, 1'b0, 2'h0);
        stat(16'h0098, 16'hFC8F, 1'b0, 1'b0, 2'h3);
        stat(16'h0098, 16'h0411, 1'b1, 1'b0, 2'h1);
        stat(16'h0098, 16'h0450, 1'b0, 1'b0, 2'h2);
        acc(1'b1, 8'h01, 16'h0500, 16'h0000, 1'b0);
        stat(16'h0098, 16'h0450, 1'b0, 1'b0, 2'h0);
    endtask : t_status

    // Eleven back-to-back faults, the first one must be pushed out
    task automatic t_faults();
        int k;
        for (k = 0; k < 11; k++)
        begin
            @(posedge clk_i);
            #1;
            chk("fault_count", 16'(k), {12'h000, fault_count});
            fault_valid = 1'b1;
            fault = plfl_pkg::plfl_fault_t'({ids[k], 16'hA000 + 16'(k)});
        end
        @(posedge clk_i);
        #1;
        fault_valid = 1'b0;
        chk("fault_count", 16'h000A, {12'h000, fault_count});
        for (k = 0; k < 10; k++)
        begin
            acc(1'b0, 8'(16 + 2 * k), 16'h0000, ids[10 - k], 1'b0);
            acc(1'b0, 8'(17 + 2 * k), 16'h0000, 16'hA00A - 16'(k), 1'b0);
        end
        acc(1'b0, 8'h24, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, 8'h10, 16'h1234, 16'h0000, 1'b1);
        acc(1'b0, 8'h10, 16'h0000, 16'h1203, 1'b0);
        // A fault followed at once by a read of the newest record
        @(posedge clk_i);
        #1;
        fault_valid = 1'b1;
        fault = plfl_pkg::plfl_fault_t'({16'h3000, 16'h0123});
        fork
            acc(1'b0, 8'h10, 16'h0000, 16'h3000, 1'b0);
            begin
                @(posedge clk_i);
                #1;
                fault_valid = 1'b0;
            end
        join
        chk("fault_count", 16'h000A, {12'h000, fault_count});
        acc(1'b0, 8'h11, 16'h0000, 16'h0123, 1'b0);
    endtask : t_faults

    // Main sequence
    initial
    begin
        resetn_i = 1'b0;
        stack_temp = 16'h0000;
        amb_temp = 16'h0000;
        amb_unread = 1'b0;
        fault_valid = 1'b0;
        fault = '0;
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        t_reset();
        t_limits();
        t_status();
        t_faults();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
